// File: shared/mrmba_pkg.sv
`default_nettype none
package mrmba_pkg;

  // ****************************************
  // Register offsets and layout
  // ****************************************
  localparam logic [7:0] OWN_ADDR_OFS = 8'h00;
  localparam logic [7:0] MODE_STS_OFS = 8'hb8;
  localparam logic [7:0] LINK_FAULT_OFS = 8'hb9;
  localparam int OVR_BIT = 0;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam logic [6:0] OWN_ADDR_RST = 7'h00;
  localparam logic OVR_RST = 1'b0;
  localparam logic [7:0] GEN_RST = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hff;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int NUM_MAPPED = 47;

  // Offsets written into the storage bank; 0xb8 and 0xb9 read back the strap and the tally instead
  localparam logic [7:0] MAP_OFFSETS [NUM_MAPPED] = '{
    8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c,
    8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74,
    8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c,
    8'h7d, 8'h7e, 8'h7f, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94,
    8'h95, 8'h96, 8'h97, 8'ha5, 8'hb0, 8'hb1, 8'hb2, 8'hb3,
    8'hb6, 8'hb8, 8'hb9, 8'hba, 8'hbe, 8'hd0, 8'hd2
  };

  // ****************************************
  // Serial target states
  // ****************************************
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ADDR  = 7'b0000010,
    ST_ACK_A = 7'b0000100,
    ST_WDATA = 7'b0001000,
    ST_ACK_W = 7'b0010000,
    ST_RDATA = 7'b0100000,
    ST_RACK  = 7'b1000000
  } mrmba_state_e;

endpackage
`default_nettype wire

// File: rtl/mrmba_top.sv
// Behaviour
// - Strap-loaded fields default to the strap levels after reset.
// - Hardware-updated fields change by logic; reads show the latest.
// - Register 0x00 bits 7:1 hold and read back the address in use.
// - With override clear the field is read-only and shows the strap.
// - With override set the field is writable and its address is used.
// - Register 0x00 sits at offset zero and resets to zero.
`timescale 1ns/1ns
`default_nettype none
module mrmba_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b,
  input wire logic [6:0] strap_addr,
  input wire logic [7:0] strap_mode,
  input wire logic link_fault_pulse,
  output logic [6:0] own_address,
  output logic override_active
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_n;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end
    else
    begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  assign rst_n = rst_sync2_q;

  // ****************************************
  // Decoding
  // ****************************************
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < mrmba_pkg::NUM_MAPPED; i++)
    begin
      if (a == mrmba_pkg::MAP_OFFSETS[i])
        hit = 1'b1;
    end
    return hit;
  endfunction

  // ****************************************
  // Strap capture
  // ****************************************
  logic strap_done_q;
  logic [6:0] strap_addr_q;
  logic [7:0] mode_sts_q;

  // Sampled one edge after release, never inside the reset itself
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done_q <= 1'b0;
      strap_addr_q <= mrmba_pkg::OWN_ADDR_RST;
      mode_sts_q <= mrmba_pkg::GEN_RST;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      strap_addr_q <= strap_addr;
      mode_sts_q <= strap_mode;
    end
  end

  // ****************************************
  // Pin sampling and bus events
  // ****************************************
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign bus_start = scl_in && scl_q && sda_q && !sda_in;
  assign bus_stop = scl_in && scl_q && !sda_q && sda_in;

  // ****************************************
  // Serial target
  // ****************************************
  mrmba_pkg::mrmba_state_e st_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic first_q;
  logic rw_q;
  logic nack_q;
  logic drive_q;
  logic [6:0] eff_addr_q;
  logic [7:0] rd_data;
  logic wr_en;
  logic byte_end;

  assign byte_end = scl_fall && (bit_cnt_q == mrmba_pkg::BYTE_BITS);
  assign wr_en = (st_q == mrmba_pkg::ST_WDATA) && byte_end && !first_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= mrmba_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      first_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      drive_q <= 1'b0;
    end
    else if (bus_start)
    begin
      // Repeated start is taken from any state
      st_q <= mrmba_pkg::ST_ADDR;
      bit_cnt_q <= 4'h0;
      drive_q <= 1'b0;
    end
    else if (bus_stop)
    begin
      st_q <= mrmba_pkg::ST_IDLE;
      drive_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        mrmba_pkg::ST_ADDR:
        begin
          if (scl_rise)
          begin
            shift_q <= {shift_q[6:0], sda_in};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (byte_end)
          begin
            if (shift_q[7:1] == eff_addr_q)
            begin
              st_q <= mrmba_pkg::ST_ACK_A;
              rw_q <= shift_q[0];
              drive_q <= 1'b1;
            end
            else
              st_q <= mrmba_pkg::ST_IDLE;
          end
        end
        mrmba_pkg::ST_ACK_A:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= 4'h0;
            if (rw_q)
            begin
              st_q <= mrmba_pkg::ST_RDATA;
              tx_q <= rd_data;
              drive_q <= !rd_data[7];
            end
            else
            begin
              st_q <= mrmba_pkg::ST_WDATA;
              first_q <= 1'b1;
              drive_q <= 1'b0;
            end
          end
        end
        mrmba_pkg::ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_q <= {shift_q[6:0], sda_in};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (byte_end)
          begin
            // First byte after the address is the register pointer
            st_q <= mrmba_pkg::ST_ACK_W;
            drive_q <= 1'b1;
            first_q <= 1'b0;
            ptr_q <= first_q ? shift_q : ptr_q + 8'h01;
          end
        end
        mrmba_pkg::ST_ACK_W:
        begin
          if (scl_fall)
          begin
            st_q <= mrmba_pkg::ST_WDATA;
            bit_cnt_q <= 4'h0;
            drive_q <= 1'b0;
          end
        end
        mrmba_pkg::ST_RDATA:
        begin
          if (scl_rise)
            bit_cnt_q <= bit_cnt_q + 4'h1;
          else if (byte_end)
          begin
            st_q <= mrmba_pkg::ST_RACK;
            drive_q <= 1'b0;
            ptr_q <= ptr_q + 8'h01;
          end
          else if (scl_fall)
          begin
            tx_q <= {tx_q[6:0], 1'b0};
            drive_q <= !tx_q[6];
          end
        end
        mrmba_pkg::ST_RACK:
        begin
          if (scl_rise)
            nack_q <= sda_in;
          else if (scl_fall)
          begin
            bit_cnt_q <= 4'h0;
            if (nack_q)
              st_q <= mrmba_pkg::ST_IDLE;
            else
            begin
              st_q <= mrmba_pkg::ST_RDATA;
              tx_q <= rd_data;
              drive_q <= !rd_data[7];
            end
          end
        end
        default:
          st_q <= mrmba_pkg::ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_b = !drive_q;

  // ****************************************
  // Own address register
  // ****************************************
  logic override_q;
  logic [6:0] wr_addr_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      override_q <= mrmba_pkg::OVR_RST;
      wr_addr_q <= mrmba_pkg::OWN_ADDR_RST;
    end
    else if (wr_en && ptr_q == mrmba_pkg::OWN_ADDR_OFS)
    begin
      override_q <= shift_q[mrmba_pkg::OVR_BIT];
      // Field only accepts data while override is selected
      if (shift_q[mrmba_pkg::OVR_BIT])
        wr_addr_q <= shift_q[mrmba_pkg::ADDR_MSB:mrmba_pkg::ADDR_LSB];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      eff_addr_q <= mrmba_pkg::OWN_ADDR_RST;
    else if (override_q)
      eff_addr_q <= wr_addr_q;
    else
      eff_addr_q <= strap_addr_q;
  end

  assign own_address = eff_addr_q;
  assign override_active = override_q;

  // ****************************************
  // Hardware-updated tally
  // ****************************************
  logic [7:0] tally_q;

  // Hardware event wins over a host write in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tally_q <= mrmba_pkg::GEN_RST;
    else if (link_fault_pulse && tally_q != mrmba_pkg::TALLY_MAX)
      tally_q <= tally_q + 8'h01;
    else if (!link_fault_pulse && wr_en &&
             ptr_q == mrmba_pkg::LINK_FAULT_OFS)
      tally_q <= shift_q;
  end

  // ****************************************
  // Storage bank
  // ****************************************
  logic [7:0] mem_q [256];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 256; i++)
        mem_q[i] <= mrmba_pkg::GEN_RST;
    end
    else if (wr_en && is_mapped(ptr_q))
      mem_q[ptr_q] <= shift_q;
  end

  always_comb
  begin
    if (ptr_q == mrmba_pkg::OWN_ADDR_OFS)
      rd_data = {eff_addr_q, override_q};
    else if (ptr_q == mrmba_pkg::MODE_STS_OFS)
      rd_data = mode_sts_q;
    else if (ptr_q == mrmba_pkg::LINK_FAULT_OFS)
      rd_data = tally_q;
    else if (is_mapped(ptr_q))
      rd_data = mem_q[ptr_q];
    else
      rd_data = 8'h00;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_strap_load;
    $rose(strap_done_q) |-> strap_addr_q == $past(strap_addr) &&
      mode_sts_q == $past(strap_mode);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("strap levels not captured");

  property p_tally_count;
    link_fault_pulse && tally_q != mrmba_pkg::TALLY_MAX |=>
      tally_q == $past(tally_q) + 8'h01;
  endproperty
  a_tally_count: assert property (p_tally_count)
    else $error("fault tally did not count");

  sequence s_addr_done;
    st_q == mrmba_pkg::ST_ADDR && byte_end;
  endsequence

  property p_addr_match;
    s_addr_done and (shift_q[7:1] == eff_addr_q) |=>
      st_q == mrmba_pkg::ST_ACK_A && drive_q;
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("own address not acknowledged");

  property p_addr_miss;
    s_addr_done and (shift_q[7:1] != eff_addr_q) |=>
      st_q == mrmba_pkg::ST_IDLE && !drive_q;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign address acknowledged");

  property p_strap_in_use;
    (!override_q && strap_done_q)[*2] |-> eff_addr_q == strap_addr_q;
  endproperty
  a_strap_in_use: assert property (p_strap_in_use)
    else $error("strapped address not in use");

  sequence s_ovr_write;
    wr_en && ptr_q == mrmba_pkg::OWN_ADDR_OFS &&
      shift_q[mrmba_pkg::OVR_BIT];
  endsequence

  property p_ovr_write;
    s_ovr_write |=> override_q && wr_addr_q == $past(shift_q[7:1])
      ##1 eff_addr_q == wr_addr_q;
  endproperty
  a_ovr_write: assert property (p_ovr_write)
    else $error("override address not taken");

  property p_reset_value;
    $rose(rst_n) |-> !override_q && wr_addr_q == mrmba_pkg::OWN_ADDR_RST;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("address register reset wrong");

  property p_revert;
    $fell(override_q) && strap_done_q |=> eff_addr_q == strap_addr_q;
  endproperty
  a_revert: assert property (p_revert)
    else $error("no return to strapped address");

endmodule // mrmba_top
`default_nettype wire

// File: tb/mrmba_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Serial bus host model
// ****************************************
module mrmba_host_model (
  input wire logic clock,
  input wire logic sda,
  output var logic scl,
  output var logic sda_drv
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Data moves mid-low only, so no false START or STOP
  task automatic bit_io(input logic v, output logic s);
    tick(2);
    sda_drv = v;
    tick(3);
    scl = 1'b1;
    tick(4);
    s = sda;
    tick(1);
    scl = 1'b0;
  endtask

  task automatic start();
    tick(2);
    sda_drv = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(5);
    sda_drv = 1'b0;
    tick(5);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_drv = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(5);
    sda_drv = 1'b1;
    tick(5);
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask

  // Override select travels in bit 0 of the data byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] data, output logic ack);
    logic a0, a1, a2;
    start();
    send({dev, 1'b0}, a0);
    send(ofs, a1);
    send(data, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                          output logic [7:0] data, output logic ack);
    logic a0, a1, a2;
    start();
    send({dev, 1'b0}, a0);
    send(ofs, a1);
    start();
    send({dev, 1'b1}, a2);
    recv(1'b1, data);
    stop();
    ack = a0 & a1 & a2;
  endtask
endmodule // mrmba_host_model
`default_nettype wire

// File: tb/tb_main_register_map_bus_address.sv
`timescale 1ns/1ns
`default_nettype none
module tb_main_register_map_bus_address;
  typedef struct {
    logic [7:0] ofs;
    logic [7:0] wr;
    logic [7:0] exp;
  } mrmba_row_s;

  // ****************************************
  // Write then read back, strap address 0x2a
  // ****************************************
  mrmba_row_s rows [5] = '{
    '{8'h65, 8'ha5, 8'ha5}, '{8'hd2, 8'h3c, 8'h3c},
    '{8'hb8, 8'hff, 8'h5c}, '{8'h01, 8'h77, 8'h00},
    '{8'h00, 8'h40, 8'h54}
  };
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [6:0] strap_addr = 7'h2a;
  logic [7:0] strap_mode = 8'h5c;
  logic link_fault_pulse = 1'b0;
  logic sda_out;
  logic sda_oe_b;
  logic [6:0] own_address;
  logic override_active;
  logic [7:0] rd;
  logic ack;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  wire logic scl;
  wire logic sda_drv;
  // Open-drain wire with pull-up
  wire logic sda = sda_drv & (sda_oe_b | sda_out);

  always #50 clock = ~clock;

  mrmba_top DUT (
    .clock(clock),
    .rst_b(rst_b),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe_b(sda_oe_b),
    .strap_addr(strap_addr),
    .strap_mode(strap_mode),
    .link_fault_pulse(link_fault_pulse),
    .own_address(own_address),
    .override_active(override_active)
  );

  mrmba_host_model host (
    .clock(clock),
    .sda(sda),
    .scl(scl),
    .sda_drv(sda_drv)
  );

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse_fault(input int n);
    repeat (n)
    begin
      link_fault_pulse = 1'b1;
      @(negedge clock);
      link_fault_pulse = 1'b0;
      @(negedge clock);
    end
  endtask

  // Run is some 7290 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
  end

  initial
  begin
    repeat (2) @(negedge clock);
    chk("own_address in reset", 8'h00, {1'b0, own_address});
    rst_b = 1'b1;
    repeat (8) @(negedge clock);
    chk("strapped address", 8'h2a, {1'b0, own_address});
    chk("override after reset", 8'h00, {7'h00, override_active});
    host.read_reg(7'h2a, mrmba_pkg::MODE_STS_OFS, rd, ack);
    chk("mode strap", 8'h5c, rd);
    chk("mode strap ack", 8'h01, {7'h00, ack});
    for (int i = 0; i < 5; i++)
    begin
      host.write_reg(7'h2a, rows[i].ofs, rows[i].wr, ack);
      chk("row write ack", 8'h01, {7'h00, ack});
      host.read_reg(7'h2a, rows[i].ofs, rd, ack);
      chk("row read ack", 8'h01, {7'h00, ack});
      chk("row readback", rows[i].exp, rd);
    end
    pulse_fault(3);
    host.read_reg(7'h2a, mrmba_pkg::LINK_FAULT_OFS, rd, ack);
    chk("fault tally", 8'h03, rd);
    // Host preload, then hardware counts on and stops at full scale
    host.write_reg(7'h2a, mrmba_pkg::LINK_FAULT_OFS, 8'hfe, ack);
    chk("tally write ack", 8'h01, {7'h00, ack});
    pulse_fault(2);
    host.read_reg(7'h2a, mrmba_pkg::LINK_FAULT_OFS, rd, ack);
    chk("tally saturated", 8'hff, rd);
    host.write_reg(7'h2a, mrmba_pkg::OWN_ADDR_OFS, 8'hab, ack);
    chk("override address", 8'h55, {1'b0, own_address});
    chk("override flag", 8'h01, {7'h00, override_active});
    host.read_reg(7'h55, 8'h00, rd, ack);
    chk("address register", 8'hab, rd);
    host.read_reg(7'h2a, 8'h00, rd, ack);
    chk("old address ack", 8'h00, {7'h00, ack});
    host.write_reg(7'h55, 8'h00, 8'h00, ack);
    chk("reverted address", 8'h2a, {1'b0, own_address});
    host.read_reg(7'h2a, 8'h00, rd, ack);
    chk("reverted register", 8'h54, rd);
    // Second reset picks up a changed strap
    strap_addr = 7'h31;
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    repeat (8) @(negedge clock);
    chk("override after reset", 8'h00, {7'h00, override_active});
    host.read_reg(7'h31, 8'h00, rd, ack);
    chk("new strap register", 8'h62, rd);
    summarize();
  end
endmodule // tb_main_register_map_bus_address
`default_nettype wire
